// ==== core/swgear_consts.svh ====
// constants for the switchgear object control block
// assumes a 100 MHz ref_clk_in and a 32-bit APB register port
`ifndef SWGEAR_CONSTS_SVH
`define SWGEAR_CONSTS_SVH
// clock and time base
`define CLK_PERIOD_NS   10
`define TICK_PERIOD_NS  1000000
`define TICK_CYCLES     (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
// register byte offsets
`define REG_CTRL        8'h00
`define REG_CMD         8'h04
`define REG_STATUS      8'h08
`define REG_TRAVERSE    8'h0c
`define REG_CLOSE_PULSE 8'h10
`define REG_OPEN_PULSE  8'h14
`define REG_TERM_TIME   8'h18
`define REG_DI_POL      8'h1c
`define REG_DO_POL      8'h20
`define REG_MAP_LATCH   8'h24
`define REG_BLK_SEL     8'h28
`define REG_LOGIC_IN    8'h2c
`define REG_EVT_STAT    8'h30
`define REG_EVT_MASK    8'h34
`define REG_REC_IDX     8'h38
`define REG_REC_DATA    8'h3c
`define REG_DI_DLY_BASE 8'h40
// ctrl fields
`define CTRL_REMOTE     0
`define CTRL_USE_SYNC   1
`define CTRL_USE_READY  2
`define CTRL_BLK_EN     3
`define CTRL_CLR_LATCH  8
`define CTRL_CLR_REC    9
// event bits
`define EV_OPEN_REQ     0
`define EV_CLOSE_REQ    1
`define EV_OPEN_FAIL    2
`define EV_CLOSE_FAIL   3
`define EV_INTER        4
`define EV_BAD          5
`define EV_DONE         6
// sizes and reset values
`define NUM_DI          4
`define NUM_EV          7
`define REC_DEPTH       12
`define MS_W            21
`define TIME_RST        21'h0003e8
`endif

// ==== core/swgear_pkg.sv ====
// types shared by the switchgear object control block
// assumes nothing from the constants header; widths and encodings are literal here
package swgear_pkg;
   // command sequencer states, one-hot
   typedef enum logic [2:0] {
      C_IDLE  = 3'b001,
      C_PULSE = 3'b010,
      C_WAIT  = 3'b100
   } cmd_state_e;
   // object status from {close input, open input}
   typedef enum logic [1:0] {
      ST_INTER  = 2'b00,
      ST_OPEN   = 2'b01,
      ST_CLOSED = 2'b10,
      ST_BAD    = 2'b11
   } obj_status_e;
   typedef logic [20:0] ms_t;
endpackage

// ==== core/swgear_ctrl.sv ====
// switchgear object control: command pulses, supervision, input/output
// conditioning, operation record, event mask and APB register port.
// assumes di_in pins are asynchronous; app_* and stage_* are on ref_clk_in.
// Notes on behaviour
// - command pulse capped, cut at reached state
// - target status not reached by timeout: fail
// - intermediate reported only after traverse time
// - application requests bypass local/remote selection
// - each status mapping latched or non-latched
// - latched mapping needs source low plus clear
// - masks reset off; record only masked events
// - selectable blocking source blocks the object
// - twelve-entry operation record, clear empties all
// - per-input polarity normally open or closed
// - per-input activation and release delays
// - per-output polarity, normally open at reset
// - status decoded from open and close inputs
// - close refused without enabled sync/ready
// - local ignores remote commands, remote ignores local
`timescale 1ns/1ns
`include "swgear_consts.svh"
module swgear_ctrl
   import swgear_pkg::*;
#(
   parameter int TICK_CYC = `TICK_CYCLES  // cycles per 1 ms tick
) (
   // clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        reset_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // field pins and application signals
   input  wire logic [3:0]  di_in,
   input  wire logic        app_open_in,
   input  wire logic        app_close_in,
   input  wire logic [2:0]  stage_sig_in,
   // coils, relays and interrupt
   output logic [3:0]       do_out,
   output logic             irq_out
);
   // saturating ms increment
   function automatic ms_t inc_ms(input ms_t v);
      return (v == '1) ? v : ms_t'(v + 1'b1);
   endfunction

   logic [16:0] div_q;                       // tick divider
   logic        tick_q;                      // 1 ms enable pulse
   logic [3:0]  di_s1_q, di_s2_q;            // input synchroniser
   logic [3:0]  di_cond_q;                   // conditioned inputs
   ms_t         di_cnt_q [`NUM_DI];          // input delay counters
   ms_t         di_act_q [`NUM_DI];          // activation delays
   ms_t         di_rel_q [`NUM_DI];          // release delays
   logic [31:0] ctrl_q;                      // control bits
   ms_t         trav_q, cpulse_q, opulse_q, term_q;
   logic [3:0]  di_pol_q, do_pol_q;          // polarities
   logic [1:0]  latch_q, lat_hold_q;         // mapping modes, latches
   logic [4:0]  blk_sel_q;                   // blocking source index
   logic [7:0]  logic_in_q;                  // logical inputs
   logic [6:0]  ev_stat_q, ev_mask_q;        // events
   logic [3:0]  rec_idx_q, rec_wp_q, rec_cnt_q;
   logic [22:0] rec_q [`REC_DEPTH];          // {fail, close, ms}
   cmd_state_e  st_q;                        // sequencer state
   logic        tgt_close_q;                 // commanded direction
   ms_t         cmd_ms_q, trav_ms_q;         // command and traverse timers
   logic        inter_rep_q;                 // intermediate reported
   logic        pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic [3:0]  do_q;
   logic        irq_q;

   // bus decode
   logic        acc, wr;
   logic [31:0] rd_mux;
   logic        hit;
   assign acc = psel_in & penable_in & ~pready_q;
   assign wr  = psel_in & penable_in & pready_q & pwrite_in;

   // object status and derived signals
   obj_status_e obj;
   logic        blocked, reached, pulse_on;
   logic [16:0] blk_src;
   assign obj = obj_status_e'({di_cond_q[1], di_cond_q[0]});
   assign blk_src = {stage_sig_in, obj == ST_CLOSED, obj == ST_OPEN,
                     logic_in_q, di_cond_q};
   assign blocked = ctrl_q[`CTRL_BLK_EN] &
                    (blk_sel_q <= 5'd16) & blk_src[blk_sel_q];
   assign reached = tgt_close_q ? (obj == ST_CLOSED) : (obj == ST_OPEN);
   assign pulse_on = (st_q == C_PULSE);

   // request arbitration
   logic loc, rem, req_o, req_c, ok_c, go_o, go_c;
   assign loc = ~ctrl_q[`CTRL_REMOTE];
   assign rem = ctrl_q[`CTRL_REMOTE];
   // each source only while its side holds control; app always
   assign req_o = app_open_in | (wr && paddr_in == `REG_CMD &&
                  ((loc & pwdata_in[0]) | (rem & pwdata_in[2])));
   assign req_c = app_close_in | (wr && paddr_in == `REG_CMD &&
                  ((loc & pwdata_in[1]) | (rem & pwdata_in[3])));
   assign ok_c = (~ctrl_q[`CTRL_USE_SYNC] | di_cond_q[3]) &
                 (~ctrl_q[`CTRL_USE_READY] | di_cond_q[2]);
   assign go_o = (st_q == C_IDLE) & ~blocked & req_o;
   assign go_c = (st_q == C_IDLE) & ~blocked & ~req_o & req_c & ok_c;

   // 1 ms tick divider
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         div_q  <= 17'h0;
         tick_q <= 1'b0;
      end else if (div_q == 17'(TICK_CYC - 1)) begin
         div_q  <= 17'h0;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 17'h1;
         tick_q <= 1'b0;
      end
   end

   // two-stage synchroniser on field pins
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         di_s1_q <= 4'h0;
         di_s2_q <= 4'h0;
      end else begin
         di_s1_q <= di_in;
         di_s2_q <= di_s1_q;
      end
   end

   // input polarity and activation/release delays
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         di_cond_q <= 4'h0;
         for (int i = 0; i < `NUM_DI; i++) di_cnt_q[i] <= '0;
      end else begin
         for (int i = 0; i < `NUM_DI; i++) begin
            if ((di_s2_q[i] ^ di_pol_q[i]) == di_cond_q[i]) begin
               di_cnt_q[i] <= '0;  // restart on each new transition
            end else if (di_cnt_q[i] >=
                         (di_cond_q[i] ? di_rel_q[i] : di_act_q[i])) begin
               di_cond_q[i] <= ~di_cond_q[i];
               di_cnt_q[i]  <= '0;
            end else if (tick_q) begin
               di_cnt_q[i] <= inc_ms(di_cnt_q[i]);
            end
         end
      end
   end

   // command sequencer
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         st_q        <= C_IDLE;
         tgt_close_q <= 1'b0;
         cmd_ms_q    <= '0;
      end else begin
         unique case (st_q)
            C_IDLE: begin
               if (go_o | go_c) begin
                  st_q        <= C_PULSE;
                  tgt_close_q <= go_c;
                  cmd_ms_q    <= '0;
               end
            end
            C_PULSE: begin
               if (tick_q) cmd_ms_q <= inc_ms(cmd_ms_q);
               if (reached) begin
                  st_q <= C_IDLE;  // cut short
               end else if (cmd_ms_q >= term_q) begin
                  st_q <= C_IDLE;
               end else if (cmd_ms_q >= (tgt_close_q ? cpulse_q : opulse_q)) begin
                  st_q <= C_WAIT;
               end
            end
            C_WAIT: begin
               if (tick_q) cmd_ms_q <= inc_ms(cmd_ms_q);
               if (reached | (cmd_ms_q >= term_q)) st_q <= C_IDLE;
            end
            default: st_q <= C_IDLE;
         endcase
      end
   end

   // traverse supervision
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         trav_ms_q   <= '0;
         inter_rep_q <= 1'b0;
      end else if (obj != ST_INTER) begin
         trav_ms_q   <= '0;
         inter_rep_q <= 1'b0;
      end else begin
         if (tick_q) trav_ms_q <= inc_ms(trav_ms_q);
         if (trav_ms_q > trav_q) inter_rep_q <= 1'b1;
      end
   end

   // event sources this cycle
   logic       done, fail;
   logic [6:0] ev_set;
   assign done = (st_q != C_IDLE) & reached;
   assign fail = (st_q != C_IDLE) & ~reached & (cmd_ms_q >= term_q);
   assign ev_set = {done, obj == ST_BAD,
                    (obj == ST_INTER) & ~inter_rep_q & (trav_ms_q > trav_q),
                    fail & tgt_close_q, fail & ~tgt_close_q, go_c, go_o};

   // sticky events, set beats write-one-to-clear
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         ev_stat_q <= 7'h0;
      end else if (wr && paddr_in == `REG_EVT_STAT) begin
         ev_stat_q <= (ev_stat_q & ~pwdata_in[6:0]) | ev_set;
      end else begin
         ev_stat_q <= ev_stat_q | ev_set;
      end
   end

   // operation record, only masked outcomes are stored
   logic rec_we;
   assign rec_we = (done & ev_mask_q[`EV_DONE]) |
                   (fail & ev_mask_q[tgt_close_q ? `EV_CLOSE_FAIL : `EV_OPEN_FAIL]);
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         rec_wp_q  <= 4'h0;
         rec_cnt_q <= 4'h0;
         for (int i = 0; i < `REC_DEPTH; i++) rec_q[i] <= 23'h0;
      end else if (wr && paddr_in == `REG_CTRL && pwdata_in[`CTRL_CLR_REC]) begin
         rec_wp_q  <= 4'h0;
         rec_cnt_q <= 4'h0;
         for (int i = 0; i < `REC_DEPTH; i++) rec_q[i] <= 23'h0;
      end else if (rec_we) begin
         rec_q[rec_wp_q] <= {fail, tgt_close_q, cmd_ms_q};
         rec_wp_q  <= (rec_wp_q == 4'(`REC_DEPTH - 1)) ? 4'h0 : rec_wp_q + 4'h1;
         if (rec_cnt_q != 4'(`REC_DEPTH)) rec_cnt_q <= rec_cnt_q + 4'h1;
      end
   end

   // mapping latches for open and closed status relays
   logic [1:0] map_src;
   assign map_src = {obj == ST_CLOSED, obj == ST_OPEN};
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         lat_hold_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (map_src[i]) begin
               lat_hold_q[i] <= latch_q[i];
            end else if (wr && paddr_in == `REG_CTRL &&
                         pwdata_in[`CTRL_CLR_LATCH]) begin
               lat_hold_q[i] <= 1'b0;
            end
         end
      end
   end

   // output stage with polarity: coils then relays
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         do_q  <= 4'h0;
         irq_q <= 1'b0;
      end else begin
         do_q  <= {map_src | lat_hold_q,
                   pulse_on & tgt_close_q, pulse_on & ~tgt_close_q} ^ do_pol_q;
         irq_q <= |(ev_stat_q & ev_mask_q);
      end
   end

   // configuration registers
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         ctrl_q     <= 32'h0;  // local control by default
         trav_q     <= `TIME_RST;
         cpulse_q   <= `TIME_RST;
         opulse_q   <= `TIME_RST;
         term_q     <= `TIME_RST;
         di_pol_q   <= 4'h0;
         do_pol_q   <= 4'h0;  // normally open
         latch_q    <= 2'h0;
         blk_sel_q  <= 5'h0;
         logic_in_q <= 8'h0;
         ev_mask_q  <= 7'h0;  // all masked off
         rec_idx_q  <= 4'h0;
         for (int i = 0; i < `NUM_DI; i++) begin
            di_act_q[i] <= '0;
            di_rel_q[i] <= '0;
         end
      end else if (wr) begin
         unique case (paddr_in)
            `REG_CTRL:        ctrl_q     <= {28'h0, pwdata_in[3:0]};
            `REG_TRAVERSE:    trav_q     <= pwdata_in[20:0];
            `REG_CLOSE_PULSE: cpulse_q   <= pwdata_in[20:0];
            `REG_OPEN_PULSE:  opulse_q   <= pwdata_in[20:0];
            `REG_TERM_TIME:   term_q     <= pwdata_in[20:0];
            `REG_DI_POL:      di_pol_q   <= pwdata_in[3:0];
            `REG_DO_POL:      do_pol_q   <= pwdata_in[3:0];
            `REG_MAP_LATCH:   latch_q    <= pwdata_in[1:0];
            `REG_BLK_SEL:     blk_sel_q  <= pwdata_in[4:0];
            `REG_LOGIC_IN:    logic_in_q <= pwdata_in[7:0];
            `REG_EVT_MASK:    ev_mask_q  <= pwdata_in[6:0];
            `REG_REC_IDX:     rec_idx_q  <= pwdata_in[3:0];
            default: begin
               if (paddr_in[7:5] == 3'b010 && paddr_in[1:0] == 2'b00) begin
                  if (paddr_in[2]) di_rel_q[paddr_in[4:3]] <= pwdata_in[20:0];
                  else             di_act_q[paddr_in[4:3]] <= pwdata_in[20:0];
               end
            end
         endcase
      end
   end

   // read mux and decode of mapped addresses
   always_comb begin
      rd_mux = 32'h0;
      hit    = 1'b1;
      unique case (paddr_in)
         `REG_CTRL:        rd_mux = ctrl_q;
         `REG_CMD:         rd_mux = 32'h0;
         `REG_STATUS:      rd_mux = {18'h0, di_cond_q, st_q, blocked,
                                     inter_rep_q, 2'(obj), 3'h0};
         `REG_TRAVERSE:    rd_mux = {11'h0, trav_q};
         `REG_CLOSE_PULSE: rd_mux = {11'h0, cpulse_q};
         `REG_OPEN_PULSE:  rd_mux = {11'h0, opulse_q};
         `REG_TERM_TIME:   rd_mux = {11'h0, term_q};
         `REG_DI_POL:      rd_mux = {28'h0, di_pol_q};
         `REG_DO_POL:      rd_mux = {28'h0, do_pol_q};
         `REG_MAP_LATCH:   rd_mux = {30'h0, latch_q};
         `REG_BLK_SEL:     rd_mux = {27'h0, blk_sel_q};
         `REG_LOGIC_IN:    rd_mux = {24'h0, logic_in_q};
         `REG_EVT_STAT:    rd_mux = {25'h0, ev_stat_q};
         `REG_EVT_MASK:    rd_mux = {25'h0, ev_mask_q};
         `REG_REC_IDX:     rd_mux = {28'h0, rec_idx_q};
         `REG_REC_DATA:    rd_mux = {rec_cnt_q, 5'h0, (rec_idx_q < 4'(`REC_DEPTH))
                                     ? rec_q[rec_idx_q] : 23'h0};
         default: begin
            if (paddr_in[7:5] == 3'b010 && paddr_in[1:0] == 2'b00) begin
               rd_mux = {11'h0, paddr_in[2] ? di_rel_q[paddr_in[4:3]]
                                            : di_act_q[paddr_in[4:3]]};
            end else begin
               hit = 1'b0;
            end
         end
      endcase
   end

   // apb answer: ready on the second access cycle
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= acc;
         pslverr_q <= acc & ~hit;
         if (acc & ~pwrite_in) prdata_q <= rd_mux;
      end
   end

   assign prdata_out  = prdata_q;
   assign pready_out  = pready_q;
   assign pslverr_out = pslverr_q;
   assign do_out      = do_q;
   assign irq_out     = irq_q;
endmodule

// ==== tb/swgear_ctrl_chk.sv ====
// port checker for the switchgear object control block
// assumes coil outputs keep normally-open polarity throughout the bench
`timescale 1ns/1ns
module swgear_ctrl_chk #(
   parameter int TICK_CYC = 100000  // cycles per 1 ms tick
) (
   // watched ports
   input  wire logic        ref_clk_in,
   input  wire logic        reset_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [31:0] prdata_out,
   input  wire logic        pready_out,
   input  wire logic        pslverr_out,
   input  wire logic [3:0]  di_in,
   input  wire logic        app_open_in,
   input  wire logic        app_close_in,
   input  wire logic [2:0]  stage_sig_in,
   input  wire logic [3:0]  do_out,
   input  wire logic        irq_out
);
   logic       done_w;  // apb transfer completes this cycle
   logic [6:0] mask_q;  // snooped event mask
   logic [3:0] req_q;   // recent command requests
   assign done_w = psel_in & penable_in & pready_out;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   // follow mask writes
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         mask_q <= 7'h00;
      end else if (done_w && pwrite_in && paddr_in == 8'h34) begin
         mask_q <= pwdata_in[6:0];
      end
   end
   // remember requests of the last four cycles
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         req_q <= 4'h0;
      end else begin
         req_q <= {req_q[2:0], app_open_in | app_close_in
                   | (done_w & pwrite_in & paddr_in == 8'h04 & (|pwdata_in[3:0]))};
      end
   end
   property p_rdy_time;
      (psel_in && !penable_in) ##1 (psel_in && penable_in) |=> pready_out;
   endproperty
   a_rdy_time: assert property (p_rdy_time) else $error("late ready");
   property p_rdy_pulse;
      pready_out |=> !pready_out;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
   property p_err_rdy;
      pslverr_out |-> pready_out && psel_in && penable_in;
   endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("stray error");
   property p_err_unmapped;
      pready_out && paddr_in > 8'h5c |-> pslverr_out;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped accepted");
   property p_cmd_zero;
      pready_out && !pwrite_in && paddr_in == 8'h04 |-> prdata_out == 32'h0;
   endproperty
   a_cmd_zero: assert property (p_cmd_zero) else $error("command reads back");
   property p_coil_excl;
      !(do_out[0] && do_out[1]);
   endproperty
   a_coil_excl: assert property (p_coil_excl) else $error("both coils");
   property p_coil_cause;
      $rose(do_out[0]) || $rose(do_out[1]) |-> req_q != 4'h0;
   endproperty
   a_coil_cause: assert property (p_coil_cause) else $error("coil uncommanded");
   property p_irq_masked;
      $past(mask_q) == 7'h00 |-> !irq_out;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("masked irq");
   property p_open_stop;
      (di_in[1:0] == 2'b01) [*8] |-> !do_out[0];
   endproperty
   a_open_stop: assert property (p_open_stop) else $error("open pulse held");
   property p_close_stop;
      (di_in[1:0] == 2'b10) [*8] |-> !do_out[1];
   endproperty
   a_close_stop: assert property (p_close_stop) else $error("close pulse held");
   c_open: cover property ($rose(do_out[0]));
   c_irq: cover property ($rose(irq_out));
   c_err: cover property (pslverr_out);
endmodule
bind swgear_ctrl swgear_ctrl_chk #(.TICK_CYC(TICK_CYC)) chk_i (
   .ref_clk_in(ref_clk_in), .reset_in(reset_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .di_in(di_in), .app_open_in(app_open_in),
   .app_close_in(app_close_in), .stage_sig_in(stage_sig_in), .do_out(do_out),
   .irq_out(irq_out));

// ==== tb/swgear_obj_model.sv ====
// field-side model: status contacts and coils of one switching object
// assumes active-high coil drives; the contacts follow with a stroke time
`timescale 1ns/1ns
module swgear_obj_model #(
   parameter int TRAVEL = 30  // cycles for a full stroke
) (
   // coils and test controls
   input  wire logic       clk_in,
   input  wire logic       open_coil_in,
   input  wire logic       close_coil_in,
   input  wire logic       stuck_in,
   input  wire logic       ready_in,
   input  wire logic       sync_in,
   // contacts {sync, ready, closed, open}
   output logic      [3:0] di_out
);
   int pos = 0;  // 0 fully open, TRAVEL fully closed
   // one step a cycle while a coil pulls; a jam holds mid-stroke
   always @(posedge clk_in) begin
      if (!(stuck_in && pos == TRAVEL / 2)) begin
         if (close_coil_in && pos < TRAVEL) begin
            pos <= pos + 1;
         end else if (open_coil_in && pos > 0) begin
            pos <= pos - 1;
         end
      end
   end
   // one contact made at each end, neither mid-stroke
   assign di_out = {sync_in, ready_in, pos == TRAVEL, pos == 0};
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the switchgear object control block
// assumes the object model on the field side and apb register access
`timescale 1ns/1ns
`include "swgear_consts.svh"
module tb;
   typedef struct packed {
      logic        w;  // write, else read and compare
      logic [7:0]  a;  // byte address
      logic [31:0] d;  // write data or expected data
   } row_s;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        pready, pslverr, irq, rerr, app_open = 1'b0, stuck = 1'b0;
   logic        ready = 1'b0, sync = 1'b1, app_close = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic [2:0]  stage = 3'h0;
   logic [3:0]  di, dout;
   logic [4:0]  bsel[8] = '{5'd0, 5'd4, 5'd12, 5'd14, 5'd15, 5'd16, 5'd13, 5'd5};
   logic [7:0]  bexp = 8'h3f;  // sources that should block, by slot
   int          err_total = 0, checks = 0, cyc = 0, n;
   row_s        rows[12] = '{
      '{1'b0, 8'h00, 32'h0}, '{1'b0, 8'h0c, {11'h0, `TIME_RST}},
      '{1'b0, 8'h10, {11'h0, `TIME_RST}}, '{1'b0, 8'h14, {11'h0, `TIME_RST}},
      '{1'b0, 8'h18, {11'h0, `TIME_RST}}, '{1'b0, 8'h20, 32'h0},
      '{1'b0, 8'h34, 32'h0}, '{1'b1, 8'h0c, 32'd6}, '{1'b1, 8'h10, 32'd10},
      '{1'b1, 8'h14, 32'd10}, '{1'b1, 8'h18, 32'd20}, '{1'b0, 8'h0c, 32'd6}};
   swgear_ctrl #(.TICK_CYC(10)) DUT (
      .ref_clk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .di_in(di), .app_open_in(app_open),
      .app_close_in(app_close), .stage_sig_in(stage), .do_out(dout), .irq_out(irq));
   swgear_obj_model obj (
      .clk_in(clk), .open_coil_in(dout[0]), .close_coil_in(dout[1]),
      .stuck_in(stuck), .ready_in(ready), .sync_in(sync), .di_out(di));
   // 100 MHz clock
   initial begin
      forever #5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; waits for ready, takes data at that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(k < 20, 1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat & m, e);
   endtask
   // wait for an output level, n counts cycles
   task automatic wait_do(input int b, input logic v);
      n = 0;
      while (dout[b] !== v && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk(dout[b], v);
   endtask
   task automatic settle(input int c);
      repeat (c) @(posedge clk);
   endtask
   // main sequence
   initial begin
      settle(20);
      chk({pready, pslverr, irq, dout}, 0);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) apb(1'b1, 8'h40 + 8'(4 * i), 32'h0);
      foreach (rows[i]) begin
         if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
         else rd(rows[i].a, 32'hffffffff, rows[i].d);
      end
      rd(8'h80, 32'hffffffff, 32'h0);
      chk(rerr, 1);
      $display("end registers");
      apb(1'b1, 8'h04, 32'h8);  // bus close while local
      settle(30);
      chk(dout, 4'h4);
      rd(8'h08, 32'h18, 32'h08);
      apb(1'b1, 8'h04, 32'h2);
      wait_do(1, 1'b1);
      wait_do(1, 1'b0);
      chk(n < 60, 1);
      rd(8'h08, 32'h38, 32'h10);
      rd(8'h3c, 32'hf0000000, 32'h0);
      chk(irq, 0);
      $display("end local");
      apb(1'b1, 8'h34, 32'h7f);
      apb(1'b1, 8'h30, 32'h7f);
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b1, 8'h04, 32'h1);  // local open while remote
      settle(30);
      chk(dout, 4'h8);
      @(posedge clk) app_open <= 1'b1;
      @(posedge clk) app_open <= 1'b0;
      wait_do(0, 1'b1);
      wait_do(0, 1'b0);
      rd(8'h08, 32'h18, 32'h08);
      rd(8'h30, 32'h41, 32'h41);
      chk(irq, 1);
      rd(8'h3c, 32'hf0000000, 32'h10000000);
      apb(1'b1, 8'h30, 32'h7f);
      settle(3);
      chk(irq, 0);
      $display("end remote");
      stuck <= 1'b1;
      apb(1'b1, 8'h04, 32'h8);
      wait_do(1, 1'b1);
      settle(82);
      chk(dout[1], 1);
      rd(8'h08, 32'h20, 32'h20);
      wait_do(1, 1'b0);
      chk(n <= 25, 1);
      settle(120);
      rd(8'h08, 32'h380, 32'h080);
      rd(8'h30, 32'h08, 32'h08);
      apb(1'b1, 8'h38, 32'h1);
      rd(8'h3c, 32'hf0600000, 32'h20600000);
      $display("end failure");
      stuck <= 1'b0;
      sync <= 1'b0;
      apb(1'b1, 8'h00, 32'h3);
      apb(1'b1, 8'h04, 32'h8);
      settle(30);
      chk(dout, 0);
      sync <= 1'b1;
      settle(10);
      @(posedge clk) app_close <= 1'b1;
      @(posedge clk) app_close <= 1'b0;
      wait_do(1, 1'b1);
      wait_do(1, 1'b0);
      rd(8'h08, 32'h18, 32'h10);
      apb(1'b1, 8'h34, 32'h0);
      settle(3);
      chk(irq, 0);
      apb(1'b1, 8'h34, 32'h7f);
      settle(3);
      chk(irq, 1);
      apb(1'b1, 8'h30, 32'h7f);
      settle(3);
      chk(irq, 0);
      $display("end synchrocheck");
      apb(1'b1, 8'h58, 32'd3);
      sync <= 1'b0;
      settle(10);
      rd(8'h08, 32'h2000, 32'h0);
      sync <= 1'b1;
      settle(15);
      rd(8'h08, 32'h2000, 32'h0);
      settle(30);
      rd(8'h08, 32'h2000, 32'h2000);
      apb(1'b1, 8'h1c, 32'h4);
      settle(5);
      rd(8'h08, 32'h1000, 32'h1000);
      $display("end inputs");
      apb(1'b1, 8'h24, 32'h2);
      apb(1'b1, 8'h20, 32'h4);
      settle(3);
      chk(dout[3:2], 2'b11);
      apb(1'b1, 8'h04, 32'h4);
      wait_do(0, 1'b1);
      wait_do(0, 1'b0);
      settle(3);
      chk(dout[3:2], 2'b10);
      apb(1'b1, 8'h00, 32'h103);
      settle(3);
      chk(dout[3], 0);
      $display("end outputs");
      apb(1'b1, 8'h2c, 32'h1);
      stage <= 3'b111;
      apb(1'b1, 8'h00, 32'h9);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, 8'h28, {27'h0, bsel[i]});
         settle(4);
         rd(8'h08, 32'h40, {25'h0, bexp[i], 6'h0});
      end
      apb(1'b1, 8'h28, 32'd12);
      apb(1'b1, 8'h04, 32'h8);
      settle(30);
      chk(dout[1], 0);
      stage <= 3'b000;
      apb(1'b1, 8'h00, 32'h200);
      rd(8'h3c, 32'hf0000000, 32'h0);
      $display("end blocking");
      stop_test();
   end
endmodule
